// ---- rtl/prd_top.sv ----
// The APB register port was decided locally.
`timescale 1ns/10ps
module prd_top
   import prd_pkg::*;
(
   input wire logic i_ref_clk,
   input wire logic i_rst,
   input wire logic [prd_pkg::CFG_W-1:0] i_strap_cfg,
   input wire logic [11:0] i_paddr,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   output logic [2:0] o_clk_mode,
   output logic [3:0] o_pci_mem_x2,
   output logic [3:0] o_mem_cpu_x2,
   output logic o_mem_pll_en,
   output logic o_cpu_pll_en,
   output logic o_clocks_en,
   output logic [1:0] o_cpu_clk_src,
   output logic o_strap_defined
);
   import prd_pkg::*;

   typedef struct packed {
      logic [CFG_W-1:0] s1;
      logic [CFG_W-1:0] s2;
      logic [CFG_W-1:0] s3;
      logic [CFG_W-1:0] cfg;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
      logic [2:0] mode;
      logic [3:0] pm;
      logic [3:0] mc;
      logic mem_pll;
      logic cpu_pll;
      logic clk_en;
      logic [1:0] src;
      logic defined;
   } prd_state_s;

   prd_state_s st_reg;
   prd_state_s st_next;
   prd_mode_e dec_mode;
   logic [3:0] dec_pm;
   logic [3:0] dec_mc;
   logic dec_def;
   logic [7:0] readback;
   logic [31:0] status;

   // decode the held strap, so outputs never follow a live pin after reset
   prd_decode u_dec (
      .i_cfg(st_reg.cfg),
      .o_mode(dec_mode),
      .o_pci_mem_x2(dec_pm),
      .o_mem_cpu_x2(dec_mc),
      .o_defined(dec_def)
   );

   always_comb begin
      readback = 8'h00;
      readback[FLD_CFG_MSB:FLD_CFG_LSB] = st_reg.cfg[CFG_W-1:1];
      status = 32'h0000_0000;
      status[STATUS_MODE_LSB +: 3] = st_reg.mode;
      status[STATUS_DEFINED_BIT] = st_reg.defined;
      status[STATUS_CFG_LSB +: CFG_W] = st_reg.cfg;
   end

   always_comb begin
      st_next = st_reg;
      st_next.s1 = i_strap_cfg;
      st_next.s2 = st_reg.s1;
      st_next.s3 = st_reg.s2;
      // track the strap only while reset stands; frozen after release
      if (i_rst && (st_reg.s2 == st_reg.s3)) begin
         st_next.cfg = st_reg.s3;
      end
      st_next.mode = dec_mode;
      st_next.pm = dec_pm;
      st_next.mc = dec_mc;
      st_next.defined = dec_def;
      st_next.mem_pll = 1'b1;
      st_next.cpu_pll = 1'b1;
      st_next.clk_en = 1'b1;
      st_next.src = PRD_SRC_NONE;
      case (dec_mode)
         PRD_MEM_BYPASS: begin
            st_next.mem_pll = 1'b0;
         end
         PRD_SINGLE_BYPASS: begin
            st_next.mem_pll = 1'b0;
            st_next.cpu_pll = 1'b0;
            st_next.src = PRD_SRC_PCI;
         end
         PRD_DUAL_BYPASS: begin
            // oscillator assumed synchronous to pci clock here
            st_next.mem_pll = 1'b0;
            st_next.cpu_pll = 1'b0;
            st_next.src = PRD_SRC_OSC;
         end
         PRD_CLOCK_OFF, PRD_RESERVED: begin
            // reserved codes are parked in clock off as the safe state
            st_next.mem_pll = 1'b0;
            st_next.cpu_pll = 1'b0;
            st_next.clk_en = 1'b0;
         end
         default: begin
         end
      endcase
      // apb: one wait-free access phase, read only map
      st_next.pready = 1'b0;
      st_next.pslverr = 1'b0;
      st_next.prdata = 32'h0000_0000;
      if (i_psel && !i_penable) begin
         st_next.pready = 1'b1;
         if (i_pwrite) begin
            st_next.pslverr = 1'b1;
         end else if (i_paddr == ADDR_READBACK) begin
            st_next.prdata = {24'h00_0000, readback};
         end else if (i_paddr == ADDR_STATUS) begin
            st_next.prdata = status;
         end else begin
            st_next.pslverr = 1'b1;
         end
      end
      if (i_rst) begin
         st_next.pready = 1'b0;
         st_next.pslverr = 1'b0;
         st_next.prdata = 32'h0000_0000;
         st_next.clk_en = 1'b0;
      end
   end

   always_ff @(posedge i_ref_clk) begin
      st_reg <= st_next;
   end

   assign o_prdata = st_reg.prdata;
   assign o_pready = st_reg.pready;
   assign o_pslverr = st_reg.pslverr;
   assign o_clk_mode = st_reg.mode;
   assign o_pci_mem_x2 = st_reg.pm;
   assign o_mem_cpu_x2 = st_reg.mc;
   assign o_mem_pll_en = st_reg.mem_pll;
   assign o_cpu_pll_en = st_reg.cpu_pll;
   assign o_clocks_en = st_reg.clk_en;
   assign o_cpu_clk_src = st_reg.src;
   assign o_strap_defined = st_reg.defined;

   sequence s_off_code;
      st_reg.cfg == CFG_OFF_A || st_reg.cfg == CFG_OFF_B;
   endsequence

   property p_clock_off;
      @(posedge i_ref_clk) disable iff (i_rst)
      s_off_code |-> ##1 (!o_clocks_en && !o_mem_pll_en && !o_cpu_pll_en);
   endproperty
   a_clock_off: assert property (p_clock_off) else $error("clock off code left clocks on");

   property p_cfg_hold;
      @(posedge i_ref_clk) disable iff (i_rst)
      $stable(st_reg.cfg);
   endproperty
   a_cfg_hold: assert property (p_cfg_hold) else $error("strap value changed after reset");

   property p_single;
      @(posedge i_ref_clk) disable iff (i_rst)
      st_reg.cfg == CFG_SINGLE_BYPASS |-> ##1
         (o_cpu_clk_src == PRD_SRC_PCI && !o_mem_pll_en && o_pci_mem_x2 == 4'h2);
   endproperty
   a_single: assert property (p_single) else $error("single bypass decode wrong");

   property p_dual;
      @(posedge i_ref_clk) disable iff (i_rst)
      st_reg.cfg == CFG_DUAL_BYPASS |-> ##1
         (o_cpu_clk_src == PRD_SRC_OSC && !o_mem_pll_en && !o_cpu_pll_en);
   endproperty
   a_dual: assert property (p_dual) else $error("dual bypass decode wrong");

   property p_code0;
      @(posedge i_ref_clk) disable iff (i_rst)
      st_reg.cfg == 5'h00 |-> ##1 (o_pci_mem_x2 == 4'h6 && o_mem_cpu_x2 == 4'h5);
   endproperty
   a_code0: assert property (p_code0) else $error("code 00000 multipliers wrong");

   property p_code3;
      @(posedge i_ref_clk) disable iff (i_rst)
      st_reg.cfg == 5'h03 |-> ##1 (!o_mem_pll_en && o_mem_cpu_x2 == 4'h4);
   endproperty
   a_code3: assert property (p_code3) else $error("code 00011 decode wrong");

   sequence s_rd_setup;
      i_psel && !i_penable && !i_pwrite && i_paddr == ADDR_READBACK;
   endsequence

   property p_readback;
      @(posedge i_ref_clk) disable iff (i_rst)
      s_rd_setup |-> ##1 (o_pready && o_prdata[7:4] == st_reg.cfg[4:1] && o_prdata[3:0] == 4'h0);
   endproperty
   a_readback: assert property (p_readback) else $error("readback field wrong");

   property p_code4;
      @(posedge i_ref_clk) disable iff (i_rst)
      st_reg.cfg == 5'h04 |-> ##1 (o_pci_mem_x2 == 4'h4 && o_mem_cpu_x2 == 4'h4 && o_clocks_en);
   endproperty
   a_code4: assert property (p_code4) else $error("code 00100 multipliers wrong");

   property p_code1;
      @(posedge i_ref_clk) disable iff (i_rst)
      st_reg.cfg == 5'h01 |-> ##1 (o_pci_mem_x2 == 4'h6 && o_mem_cpu_x2 == 4'h6);
   endproperty
   a_code1: assert property (p_code1) else $error("code 00001 multipliers wrong");

   property p_code2;
      @(posedge i_ref_clk) disable iff (i_rst)
      st_reg.cfg == 5'h02 |-> ##1 (o_pci_mem_x2 == 4'h2 && o_mem_cpu_x2 == 4'h9);
   endproperty
   a_code2: assert property (p_code2) else $error("code 00010 multipliers wrong");

   // a normal code (0, 1, 2, 4) keeps both plls and the clock tree running
   property p_normal_plls;
      @(posedge i_ref_clk) disable iff (i_rst)
      (st_reg.cfg <= 5'h04 && st_reg.cfg != 5'h03) |->
         ##1 (o_mem_pll_en && o_cpu_pll_en && o_clocks_en && o_cpu_clk_src == PRD_SRC_NONE);
   endproperty
   a_normal_plls: assert property (p_normal_plls) else $error("pll off on normal code");

   property p_off_mult;
      @(posedge i_ref_clk) disable iff (i_rst)
      s_off_code |-> ##1 (o_pci_mem_x2 == MULT_BYPASS && o_mem_cpu_x2 == MULT_BYPASS);
   endproperty
   a_off_mult: assert property (p_off_mult) else $error("multiplier on in clock off");

   property p_single_cpu;
      @(posedge i_ref_clk) disable iff (i_rst)
      st_reg.cfg == CFG_SINGLE_BYPASS |-> ##1 (!o_cpu_pll_en && o_clocks_en);
   endproperty
   a_single_cpu: assert property (p_single_cpu) else $error("single bypass cpu pll on");

   property p_dual_mult;
      @(posedge i_ref_clk) disable iff (i_rst)
      st_reg.cfg == CFG_DUAL_BYPASS |->
         ##1 (o_pci_mem_x2 == 4'h2 && o_mem_cpu_x2 == 4'h2 && o_clocks_en);
   endproperty
   a_dual_mult: assert property (p_dual_mult) else $error("dual bypass ratios wrong");

   sequence s_wr_setup;
      i_psel && !i_penable && i_pwrite;
   endsequence

   // read only map: a write is answered with an error and changes nothing
   property p_write_refused;
      @(posedge i_ref_clk) disable iff (i_rst)
      s_wr_setup |-> ##1 (o_pready && o_pslverr && o_prdata == 32'h0000_0000);
   endproperty
   a_write_refused: assert property (p_write_refused) else $error("write not refused");

   // zero wait states: the answer stands for exactly one cycle
   property p_answer_once;
      @(posedge i_ref_clk) disable iff (i_rst)
      o_pready |-> ##1 !o_pready;
   endproperty
   a_answer_once: assert property (p_answer_once) else $error("pready held too long");

   sequence s_st_setup;
      i_psel && !i_penable && !i_pwrite && i_paddr == ADDR_STATUS;
   endsequence

   property p_status;
      @(posedge i_ref_clk) disable iff (i_rst)
      s_st_setup |->
         ##1 (o_pready && !o_pslverr && o_prdata[STATUS_CFG_LSB +: CFG_W] == st_reg.cfg);
   endproperty
   a_status: assert property (p_status) else $error("status word wrong");

   // strap still settling during reset, so the clock tree stays off meanwhile
   property p_rst_quiet;
      @(posedge i_ref_clk)
      i_rst |-> ##1 (!o_clocks_en && !o_pready && !o_pslverr);
   endproperty
   a_rst_quiet: assert property (p_rst_quiet) else $error("outputs active in reset");

   property p_capture;
      @(posedge i_ref_clk)
      (i_rst && st_reg.s2 == st_reg.s3) |-> ##1 st_reg.cfg == $past(st_reg.s3);
   endproperty
   a_capture: assert property (p_capture) else $error("strap not captured in reset");

   // decode lags the capture by one edge, so the first edge after release is exempt
   property p_decode_hold;
      @(posedge i_ref_clk) disable iff (i_rst)
      !$past(i_rst) |-> $stable({o_clk_mode, o_pci_mem_x2, o_mem_cpu_x2, o_strap_defined});
   endproperty
   a_decode_hold: assert property (p_decode_hold) else $error("decode moved after reset");
endmodule

// ---- rtl/prd_pkg.sv ----
package prd_pkg;
   localparam int CFG_W = 5;
   // apb byte address of the readback word (register index 0xe2, byte addr = 4*index)
   localparam logic [7:0] REG_IDX_READBACK = 8'he2;
   localparam logic [11:0] ADDR_READBACK = {2'b00, REG_IDX_READBACK, 2'b00};
   localparam logic [11:0] ADDR_STATUS = 12'h38c;
   localparam int FLD_CFG_LSB = 4;
   localparam int FLD_CFG_MSB = 7;
   localparam int STATUS_MODE_LSB = 0;
   localparam int STATUS_DEFINED_BIT = 4;
   localparam int STATUS_CFG_LSB = 8;
   // multipliers in half units: 5 means 2.5
   localparam logic [3:0] MULT_BYPASS = 4'h0;
   localparam logic [CFG_W-1:0] CFG_OFF_A = 5'h1e;
   localparam logic [CFG_W-1:0] CFG_OFF_B = 5'h1f;
   typedef enum logic [2:0] {
      PRD_NORMAL = 3'b000,
      PRD_MEM_BYPASS = 3'b001,
      PRD_SINGLE_BYPASS = 3'b011,
      PRD_DUAL_BYPASS = 3'b010,
      PRD_CLOCK_OFF = 3'b110,
      PRD_RESERVED = 3'b111
   } prd_mode_e;
   typedef enum logic [1:0] {
      PRD_SRC_NONE = 2'b00,
      PRD_SRC_PCI = 2'b01,
      PRD_SRC_OSC = 2'b11
   } prd_src_e;
   localparam logic [CFG_W-1:0] CFG_SINGLE_BYPASS = 5'h06;
   localparam logic [CFG_W-1:0] CFG_DUAL_BYPASS = 5'h07;
endpackage

// ---- rtl/prd_decode.sv ----
`timescale 1ns/10ps
module prd_decode
   import prd_pkg::*;
(
   input wire logic [prd_pkg::CFG_W-1:0] i_cfg,
   output prd_pkg::prd_mode_e o_mode,
   output logic [3:0] o_pci_mem_x2,
   output logic [3:0] o_mem_cpu_x2,
   output logic o_defined
);
   always_comb begin
      o_mode = PRD_RESERVED;
      o_pci_mem_x2 = MULT_BYPASS;
      o_mem_cpu_x2 = MULT_BYPASS;
      o_defined = 1'b1;
      case (i_cfg)
         5'h00: begin
            o_mode = PRD_NORMAL;
            o_pci_mem_x2 = 4'h6;
            o_mem_cpu_x2 = 4'h5;
         end
         5'h01: begin
            o_mode = PRD_NORMAL;
            o_pci_mem_x2 = 4'h6;
            o_mem_cpu_x2 = 4'h6;
         end
         5'h02: begin
            o_mode = PRD_NORMAL;
            o_pci_mem_x2 = 4'h2;
            o_mem_cpu_x2 = 4'h9;
         end
         5'h03: begin
            o_mode = PRD_MEM_BYPASS;
            o_pci_mem_x2 = 4'h2;
            o_mem_cpu_x2 = 4'h4;
         end
         5'h04: begin
            o_mode = PRD_NORMAL;
            o_pci_mem_x2 = 4'h4;
            o_mem_cpu_x2 = 4'h4;
         end
         CFG_SINGLE_BYPASS: begin
            // cpu straight from pci clock, 1:1 pci:mem
            o_mode = PRD_SINGLE_BYPASS;
            o_pci_mem_x2 = 4'h2;
         end
         CFG_DUAL_BYPASS: begin
            o_mode = PRD_DUAL_BYPASS;
            o_pci_mem_x2 = 4'h2;
            o_mem_cpu_x2 = 4'h2;
         end
         CFG_OFF_A, CFG_OFF_B: begin
            o_mode = PRD_CLOCK_OFF;
         end
         default: begin
            o_defined = 1'b0;
         end
      endcase
   end
endmodule

// ---- tb/prd_board_model.sv ----
`timescale 1ns/10ps
module prd_board_model #(
   parameter bit MODELLING = 1'b1
) (
   input wire logic i_clk,
   input wire logic [4:0] i_code,
   input wire logic i_apply,
   output logic [4:0] o_strap,
   output logic o_pci_clk,
   output logic o_osc_clk
);
   // strap resistors: a code that is not fitted on the board is never driven
   // single and dual bypass codes (6, 7) are fitted only on a board built for hardware modelling
   function automatic logic known(input logic [4:0] c);
      return c <= 5'h04 || (MODELLING && (c == 5'h06 || c == 5'h07)) || c >= 5'h1e;
   endfunction
   // pci and oscillator inputs come from one source, so they stay in step
   assign o_pci_clk = i_clk;
   assign o_osc_clk = i_clk;
   initial o_strap = 5'h00;
   always @(posedge i_clk) begin
      if (i_apply && known(i_code)) begin
         o_strap <= i_code;
      end
   end
endmodule

// ---- tb/prd_top_tb_top.sv ----
`timescale 1ns/10ps
module prd_top_tb_top;
   import prd_pkg::*;
   logic clk = 0;
   logic rst = 1;
   logic apply = 0;
   logic [4:0] req = 0;
   logic [4:0] strap;
   logic pci_clk, osc_clk;
   logic [11:0] paddr = 0;
   logic psel = 0;
   logic penable = 0;
   logic pwrite = 0;
   logic [31:0] pwdata = 0;
   logic [31:0] prdata;
   logic [31:0] rd;
   logic pready, pslverr, err, mpll, cpll, cen, defd;
   logic [2:0] mode, mx;
   logic [3:0] pm, mc;
   logic [1:0] src;
   int err_count = 0;
   int checks = 0;
   int c;
   int codes[$] = '{0, 1, 2, 3, 4, 6, 7, 30, 31};
   int pmx[$] = '{6, 6, 2, 2, 4, 2, 2, 0, 0};
   int mcx[$] = '{5, 6, 9, 4, 4, 0, 2, 0, 0};
   initial forever #50 clk = ~clk;
   prd_board_model u_prd_board_model (.i_clk(clk), .i_code(req), .i_apply(apply),
      .o_strap(strap), .o_pci_clk(pci_clk), .o_osc_clk(osc_clk));
   prd_top u_prd_top (.i_ref_clk(clk), .i_rst(rst), .i_strap_cfg(strap), .i_paddr(paddr),
      .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_pwdata(pwdata),
      .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .o_clk_mode(mode),
      .o_pci_mem_x2(pm), .o_mem_cpu_x2(mc), .o_mem_pll_en(mpll), .o_cpu_pll_en(cpll),
      .o_clocks_en(cen), .o_cpu_clk_src(src), .o_strap_defined(defd));
   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         err_count++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic conclude();
      $display("checks %0d errors %0d", checks, err_count);
      if (err_count == 0 && checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   // answer taken at the edge that samples pready high, request released there
   task automatic apb(input logic [11:0] a, input logic w);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1;
      penable <= 0;
      paddr <= a;
      pwrite <= w;
      pwdata <= $urandom;
      @(posedge clk);
      penable <= 1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 8);
      if (pready !== 1'b1) begin
         err_count++;
         conclude();
      end
      rd = prdata;
      err = pslverr;
      psel <= 0;
      penable <= 0;
   endtask
   initial begin
      void'($urandom(45238));
      repeat (3) @(posedge clk);
      foreach (codes[i]) begin
         c = codes[i];
         @(posedge clk);
         rst <= 1;
         req <= 5'(c);
         apply <= 1;
         repeat (6) @(posedge clk);
         rst <= 0;
         req <= 5'(codes[$urandom % 9]);
         repeat (3) @(negedge clk);
         mx = c >= 30 ? PRD_CLOCK_OFF : c == 7 ? PRD_DUAL_BYPASS : c == 6 ? PRD_SINGLE_BYPASS
            : c == 3 ? PRD_MEM_BYPASS : PRD_NORMAL;
         chk("mode", mode, mx);
         chk("clocks_en", cen, c < 30);
         chk("mem_pll_en", mpll, c < 3 || c == 4);
         chk("cpu_src", src, c == 6 ? PRD_SRC_PCI : c == 7 ? PRD_SRC_OSC : PRD_SRC_NONE);
         chk("pci_mem", pm, pmx[i]);
         chk("cpu_pll_en", cpll, c < 5);
         chk("mem_cpu", mc, mcx[i]);
         if (c == 7) begin
            chk("osc_sync", osc_clk, pci_clk);
         end
         chk("defined", defd, 1'b1);
         apb(ADDR_READBACK, 0);
         chk("readback", rd, {24'h0, c[4:1], 4'h0});
         chk("rd_err", err, 1'b0);
         apb(ADDR_STATUS, 0);
         chk("status", rd, {19'h0, c[4:0], 3'h0, 1'b1, 1'b0, mx});
      end
      apb(ADDR_READBACK, 1);
      chk("wr_err", err, 1'b1);
      apb(ADDR_READBACK, 0);
      chk("after_wr", rd, {24'h0, c[4:1], 4'h0});
      repeat (4) begin
         apb(12'h390 + 12'(($urandom % 64) * 4), 0);
         chk("unmapped_err", err, 1'b1);
         chk("unmapped_data", rd, 32'h0);
      end
      conclude();
   end
endmodule
